//--- pkg/dasp_pkg.sv
// Constants and carrier types for the dual asynchronous serial port block.
// Assumes a single 10 MHz system clock and an active-low asynchronous reset.
//
// Contract
// R1: Two independent channels, each sends and receives at the same time.
// R2: One transmit request sends one byte; one receive request returns one byte.
// R3: After reset the terminal channel runs at 9600 baud unconfigured.
// R4: A new baud setting takes effect at once when written.
// R5: Software programs the auxiliary channel baud before using it.
// R6: Rates 300 to 57600 accepted; standard rates exact, others nearest achievable. Code rounds every rate to the nearest divisor, so 9600 runs at 2.5 MHz / 260.
// R7: Bit rate is a 2.5 MHz reference divided by an integer divisor.
// R8: Blocking receive stalls until a character exists, else returns it immediately.
// R9: Receive-available answers at once, nonzero if pending, never consumes.
// R10: Blocking transmit stalls while shifting, at most one character period.
// R11: Transmit-ready answers at once, zero while the previous character is sent.
// R12: Unbuffered, a second character arriving before reading causes overrun.
// R13: Queue of length N holds N minus 4 characters; length below 5 rejected. Code caps the count at 16 and takes length 0 as single-character mode.
// R14: Receive queue stores arrivals; available means nonempty; read returns oldest.
// R15: Transmit queue stores writes and feeds the transmitter; ready means space.
// R16: Transmit path never drops; each request is held until accepted.
// R17: Software never uses one storage region as both receive and transmit queue.
// R18: Terminal channel receive queue also feeds terminal input, one shared stream.
// R19: Frame is low start, eight data bits LSB first, high stop; idle high.
// R20: Receiver samples mid-bit on the reference tick and checks the stop bit.

package dasp_pkg;

	// ****************************************
	// Clocking and rates
	// ****************************************
	localparam int unsigned CLK_HZ     = 10_000_000;
	localparam int unsigned REF_HZ     = 2_500_000;
	localparam int unsigned REF_DIV    = CLK_HZ / REF_HZ;
	localparam int unsigned BAUD_MIN   = 300;
	localparam int unsigned BAUD_MAX   = 57600;
	localparam int unsigned BAUD_RESET = 9600;
	localparam int unsigned DIV_W      = 14;
	localparam logic [DIV_W-1:0] DIV_RESET =
		DIV_W'((REF_HZ + BAUD_RESET / 2) / BAUD_RESET);

	// ****************************************
	// Frame and queue geometry
	// ****************************************
	localparam int unsigned NCHAN      = 2;
	localparam int unsigned FRAME_BITS = 10;
	localparam int unsigned Q_DEPTH    = 16;
	localparam int unsigned Q_AW       = 4;
	localparam int unsigned Q_CW       = 5;
	localparam logic [7:0]  Q_OVERHEAD = 8'h04;
	localparam logic [7:0]  Q_LEN_MIN  = 8'h05;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dasp_tx_s;

	typedef struct packed {
		logic        baud_we;
		logic [15:0] baud;
		logic        rxq_we;
		logic        txq_we;
		logic [7:0]  qlen;
	} dasp_cfg_s;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} dasp_rx_e;

endpackage

//--- core/dasp_top.sv
// Two full-duplex asynchronous serial channels with optional queues.
// Assumes requests come from logic on clk; serial inputs are asynchronous pins.
// Channel 0 is the terminal channel, channel 1 the auxiliary channel.
`timescale 1ns/1ps
`default_nettype none

module dasp_top
	import dasp_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic [NCHAN-1:0]          rxd,
	output wire logic [NCHAN-1:0]          txd,
	input  wire dasp_tx_s [NCHAN-1:0]      tx_req,
	output wire logic [NCHAN-1:0]          tx_ack,
	output wire logic [NCHAN-1:0]          tx_ready,
	input  wire logic [NCHAN-1:0]          rx_req,
	output wire logic [NCHAN-1:0]          rx_ack,
	output wire logic [NCHAN-1:0][7:0]     rx_data,
	output wire logic [NCHAN-1:0]          rx_avail,
	output wire logic [NCHAN-1:0]          overrun,
	input  wire dasp_cfg_s [NCHAN-1:0]     cfg,
	output wire logic [NCHAN-1:0]          cfg_reject
);

	// ****************************************
	// Helpers
	// ****************************************

	// Nearest integer divisor of the reference for a rate
	function automatic logic [DIV_W-1:0] baud_div(input logic [15:0] rate);
		int unsigned r;
		r = int'(rate);
		baud_div = DIV_W'((REF_HZ + r / 2) / r);
	endfunction

	// Usable characters of a queue of given length, capped by storage
	function automatic logic [Q_CW-1:0] q_cap(input logic [7:0] len);
		logic [7:0] c;
		c = len - Q_OVERHEAD;
		if (c > 8'(Q_DEPTH)) begin
			c = 8'(Q_DEPTH);
		end
		q_cap = c[Q_CW-1:0];
	endfunction

	// ****************************************
	// Shared 2.5 MHz reference tick
	// ****************************************
	logic [1:0] ref_cnt;
	logic       ref_tick;

	// One-cycle enable every fourth clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ref_cnt  <= 2'h0;
			ref_tick <= 1'b0;
		end else begin
			ref_tick <= (ref_cnt == 2'(REF_DIV - 1)); // [R7]
			if (ref_cnt == 2'(REF_DIV - 1)) begin
				ref_cnt <= 2'h0;
			end else begin
				ref_cnt <= ref_cnt + 2'h1;
			end
		end
	end

	// ****************************************
	// Channels
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < NCHAN; gi++) begin : g_ch // [R1]
			logic [DIV_W-1:0] div;
			logic             rx_meta;
			logic             rx_pin;
			dasp_rx_e         rx_state;
			logic [DIV_W-1:0] rx_cnt;
			logic [2:0]       rx_bit;
			logic [7:0]       rx_sh;
			logic             rx_done;
			logic [7:0]       rq_mem [0:Q_DEPTH-1];
			logic [Q_AW-1:0]  rq_wp;
			logic [Q_AW-1:0]  rq_rp;
			logic [Q_CW-1:0]  rq_cnt;
			logic [Q_CW-1:0]  rq_cap;
			logic [7:0]       tq_mem [0:Q_DEPTH-1];
			logic [Q_AW-1:0]  tq_wp;
			logic [Q_AW-1:0]  tq_rp;
			logic [Q_CW-1:0]  tq_cnt;
			logic [Q_CW-1:0]  tq_cap;
			logic             tq_on;
			logic             tx_busy;
			logic [DIV_W-1:0] tx_cnt;
			logic [3:0]       tx_left;
			logic [9:0]       tx_sh;
			logic             rq_push;
			logic             rq_pop;
			logic             tq_push;
			logic             tq_pop;
			logic             tq_space;
			logic [Q_CW-1:0]  next_rq_cnt;
			logic [Q_CW-1:0]  next_tq_cnt;
			logic             next_tx_busy;
			logic             r_tx_ack;
			logic             r_rx_ack;
			logic [7:0]       r_rx_data;
			logic             r_avail;
			logic             r_ready;
			logic             r_ovr;
			logic             r_rej;

			// Baud divisor; terminal and auxiliary both start at 9600
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					div <= DIV_RESET; // [R3]
				end else if (cfg[gi].baud_we
					&& cfg[gi].baud >= 16'(BAUD_MIN)
					&& cfg[gi].baud <= 16'(BAUD_MAX)) begin
					div <= baud_div(cfg[gi].baud); // [R4] [R6] [R7]
				end
			end

			// Queue setup; length 0 returns to single-character mode
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					rq_cap <= Q_CW'(1);
					tq_cap <= Q_CW'(1);
					tq_on  <= 1'b0;
					r_rej  <= 1'b0;
				end else begin
					r_rej <= 1'b0;
					if (cfg[gi].rxq_we || cfg[gi].txq_we) begin
						if (cfg[gi].qlen != 8'h00 && cfg[gi].qlen < Q_LEN_MIN) begin
							r_rej <= 1'b1; // [R13]
						end else if (cfg[gi].rxq_we) begin
							rq_cap <= (cfg[gi].qlen == 8'h00) ? Q_CW'(1)
								: q_cap(cfg[gi].qlen); // [R13]
						end else begin
							tq_cap <= (cfg[gi].qlen == 8'h00) ? Q_CW'(1)
								: q_cap(cfg[gi].qlen); // [R13]
							tq_on  <= (cfg[gi].qlen != 8'h00);
						end
					end
				end
			end

			// Two-stage synchroniser on the serial input
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					rx_meta <= 1'b1;
					rx_pin  <= 1'b1;
				end else begin
					rx_meta <= rxd[gi];
					rx_pin  <= rx_meta;
				end
			end

			// Receiver; start edge seen at reference rate, then mid-bit sampling
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					rx_state <= RX_IDLE;
					rx_cnt   <= '0;
					rx_bit   <= 3'h0;
					rx_sh    <= 8'h00;
					rx_done  <= 1'b0;
				end else begin
					rx_done <= 1'b0;
					if (ref_tick) begin
						case (rx_state)
							RX_IDLE: begin
								if (!rx_pin) begin
									rx_state <= RX_START;
									rx_cnt   <= div >> 1; // [R20]
								end
							end
							RX_START: begin
								if (rx_cnt != '0) begin
									rx_cnt <= rx_cnt - 1'b1;
								end else if (!rx_pin) begin
									rx_state <= RX_DATA;
									rx_cnt   <= div - 1'b1;
									rx_bit   <= 3'h0;
								end else begin
									rx_state <= RX_IDLE; // Glitch, not a start bit
								end
							end
							RX_DATA: begin
								if (rx_cnt != '0) begin
									rx_cnt <= rx_cnt - 1'b1;
								end else begin
									rx_sh  <= {rx_pin, rx_sh[7:1]}; // [R19]
									rx_cnt <= div - 1'b1;
									rx_bit <= rx_bit + 3'h1;
									if (rx_bit == 3'h7) begin
										rx_state <= RX_STOP;
									end
								end
							end
							RX_STOP: begin
								if (rx_cnt != '0) begin
									rx_cnt <= rx_cnt - 1'b1;
								end else begin
									rx_done  <= rx_pin; // [R20]
									rx_state <= RX_IDLE;
								end
							end
							default: begin
								rx_state <= RX_IDLE;
							end
						endcase
					end
				end
			end

			// Queue strobes; a full receive store drops the newcomer
			assign rq_push     = rx_done && (rq_cnt < rq_cap); // [R12] [R14]
			assign rq_pop      = rx_req[gi] && !r_rx_ack && (rq_cnt != '0); // [R8]
			assign tq_space    = tq_on ? (tq_cnt < tq_cap)
				: (tq_cnt == '0 && !tx_busy); // [R11] [R15]
			assign tq_push     = tx_req[gi].valid && !r_tx_ack && tq_space; // [R16]
			// Loads wait for a reference tick so the start bit is a full bit time
			assign tq_pop      = !tx_busy && (tq_cnt != '0) && ref_tick; // [R15]
			assign next_rq_cnt = rq_cnt + Q_CW'(rq_push) - Q_CW'(rq_pop);
			assign next_tq_cnt = tq_cnt + Q_CW'(tq_push) - Q_CW'(tq_pop);
			// Shifter state after this edge, so ready matches acceptance exactly
			assign next_tx_busy = tq_pop
				|| (tx_busy && !(ref_tick && tx_cnt == '0 && tx_left == 4'h0));

			// Receive store; the terminal channel's input shares this stream
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					rq_wp   <= '0;
					rq_rp   <= '0;
					rq_cnt  <= '0;
					r_avail <= 1'b0;
				end else begin
					if (rq_push) begin
						rq_wp <= rq_wp + 1'b1;
					end
					if (rq_pop) begin
						rq_rp <= rq_rp + 1'b1; // [R14] [R18]
					end
					rq_cnt  <= next_rq_cnt;
					r_avail <= (next_rq_cnt != '0); // [R9]
				end
			end

			// Receive storage words, no reset needed
			always_ff @(posedge clk) begin
				if (rq_push) begin
					rq_mem[rq_wp] <= rx_sh;
				end
			end

			// Overrun: set wins over the clear by a read
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					r_ovr <= 1'b0;
				end else if (rx_done && (rq_cnt >= rq_cap)) begin
					r_ovr <= 1'b1; // [R12]
				end else if (rq_pop) begin
					r_ovr <= 1'b0;
				end
			end

			// Receive answer; one byte per taken request
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					r_rx_ack  <= 1'b0;
					r_rx_data <= 8'h00;
				end else begin
					r_rx_ack <= rq_pop; // [R2] [R8]
					if (rq_pop) begin
						r_rx_data <= rq_mem[rq_rp]; // Oldest first [R14]
					end
				end
			end

			// Transmit store and acceptance
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					tq_wp    <= '0;
					tq_rp    <= '0;
					tq_cnt   <= '0;
					r_tx_ack <= 1'b0;
					r_ready  <= 1'b1;
				end else begin
					if (tq_push) begin
						tq_wp <= tq_wp + 1'b1;
					end
					if (tq_pop) begin
						tq_rp <= tq_rp + 1'b1;
					end
					tq_cnt   <= next_tq_cnt;
					r_tx_ack <= tq_push; // [R2] [R10]
					// Ready looks one cycle ahead so a poll never lies
					r_ready  <= tq_on ? (next_tq_cnt < tq_cap)
						: (next_tq_cnt == '0 && !next_tx_busy); // [R11]
				end
			end

			// Transmit storage words
			always_ff @(posedge clk) begin
				if (tq_push) begin
					tq_mem[tq_wp] <= tx_req[gi].data;
				end
			end

			// Transmitter; shifts start, eight data bits LSB first, stop
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					tx_busy <= 1'b0;
					tx_cnt  <= '0;
					tx_left <= 4'h0;
					tx_sh   <= 10'h3_ff; // Line idles high [R19]
				end else if (tq_pop) begin
					tx_busy <= 1'b1;
					tx_sh   <= {1'b1, tq_mem[tq_rp], 1'b0}; // [R19]
					tx_cnt  <= div - 1'b1;
					tx_left <= 4'(FRAME_BITS - 1);
				end else if (tx_busy && ref_tick) begin
					if (tx_cnt != '0) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else if (tx_left == 4'h0) begin
						tx_busy <= 1'b0; // Stop bit done, one frame max wait [R10]
					end else begin
						tx_sh   <= {1'b1, tx_sh[9:1]};
						tx_cnt  <= div - 1'b1;
						tx_left <= tx_left - 4'h1;
					end
				end
			end

			assign txd[gi]        = tx_sh[0];
			assign tx_ack[gi]     = r_tx_ack;
			assign tx_ready[gi]   = r_ready;
			assign rx_ack[gi]     = r_rx_ack;
			assign rx_data[gi]    = r_rx_data;
			assign rx_avail[gi]   = r_avail;
			assign overrun[gi]    = r_ovr;
			assign cfg_reject[gi] = r_rej;
		end
	endgenerate

endmodule

`default_nettype wire

//--- bench/dasp_assertions.sv
// Port checker for the dual serial port block.
// Assumes one clock domain; rstn is the only reset.
`timescale 1ns/1ps
`default_nettype none
module dasp_assertions
	import dasp_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rstn,
	input wire logic [NCHAN-1:0]      rxd,
	input wire logic [NCHAN-1:0]      txd,
	input wire dasp_tx_s [NCHAN-1:0]  tx_req,
	input wire logic [NCHAN-1:0]      tx_ack,
	input wire logic [NCHAN-1:0]      tx_ready,
	input wire logic [NCHAN-1:0]      rx_req,
	input wire logic [NCHAN-1:0]      rx_ack,
	input wire logic [NCHAN-1:0][7:0] rx_data,
	input wire logic [NCHAN-1:0]      rx_avail,
	input wire logic [NCHAN-1:0]      overrun,
	input wire dasp_cfg_s [NCHAN-1:0] cfg,
	input wire logic [NCHAN-1:0]      cfg_reject
);
	// ****************************************
	// Handshake and line relations
	// ****************************************
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_tx_take_cause:
		assert property (tx_ack[0] |-> $past(tx_req[0].valid && tx_ready[0]))
		else $error("tx ack without a ready request");
	a_start_after_ack:
		assert property (tx_ack[0] |-> ##[1:4] $fell(txd[0])) else $error("no start bit after ack");
	a_busy_not_ready:
		assert property ($fell(txd[0]) |=> !tx_ready[0]) else $error("ready while sending");
	a_ack_one_cycle:
		assert property (tx_ack[1] |=> !tx_ack[1]) else $error("tx ack too long");
	a_rx_take_cause:
		assert property (rx_ack[0] |-> $past(rx_req[0] && rx_avail[0]))
		else $error("rx ack without pending byte");
	a_avail_kept:
		assert property (rx_avail[1] && !rx_req[1] |=> rx_avail[1]) else $error("avail lost");
	a_overrun_set:
		assert property ($rose(overrun[1]) |-> rx_avail[1]) else $error("overrun, empty store");
	a_overrun_sticky:
		assert property (overrun[1] && !rx_req[1] && !rx_ack[1] |=> overrun[1])
		else $error("overrun cleared early");
	a_reject_short:
		assert property (cfg[1].rxq_we && cfg[1].qlen inside {[8'h01:8'h04]} |=> cfg_reject[1])
		else $error("short queue not refused");
	a_reject_cause:
		assert property (cfg_reject[1] |-> $past(cfg[1].rxq_we || cfg[1].txq_we))
		else $error("refusal without setup");
	// Main scenarios reached
	cover property (tx_ack[1] && !tx_ready[1]);
	cover property ($rose(overrun[1]));
	cover property (rx_ack[1] && rx_avail[1]);
endmodule
`default_nettype wire

//--- bench/dasp_partner.sv
// Remote serial device on one line: sends frames and decodes the block's frames.
// Assumes the bench sets bit_clk to the agreed bit time in clocks.
`timescale 1ns/1ps
`default_nettype none
module dasp_partner (
	input  wire logic clk,
	input  wire logic txd,
	output var  logic rxd
);
	int         bit_clk = 1040;
	int         n_got = 0;
	logic [7:0] got = 8'h00;
	logic       stop_ok = 1'b0;
	// Line rests at mark level between frames
	initial rxd = 1'b1;
	// Start low, data LSB first, stop high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (bit_clk) @(negedge clk);
		end
	endtask
	// Mid-bit decode so edge jitter cannot flip a bit
	always begin
		@(negedge txd);
		repeat (bit_clk / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clk) @(negedge clk);
			got[i] = txd;
		end
		repeat (bit_clk) @(negedge clk);
		stop_ok = txd;
		n_got++;
	end
endmodule
`default_nettype wire

//--- bench/dasp_top_bench.sv
// Self-checking bench for the dual serial port block.
// Assumes one partner model per channel line and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module dasp_top_bench
	import dasp_pkg::*;
;
	localparam int         LIM = 20000;
	logic                  clk;
	logic                  rstn;
	wire logic [NCHAN-1:0] rxd;
	logic [NCHAN-1:0]      txd, tx_ack, tx_ready, rx_req, rx_ack, rx_avail, overrun, cfg_reject;
	logic [NCHAN-1:0][7:0] rx_data;
	dasp_tx_s [NCHAN-1:0]  tx_req;
	dasp_cfg_s [NCHAN-1:0] cfg;
	int                    n_mismatch = 0;
	int                    checks = 0;

	dasp_top i_dut (.clk, .rstn, .rxd, .txd, .tx_req, .tx_ack, .tx_ready, .rx_req,
		.rx_ack, .rx_data, .rx_avail, .overrun, .cfg, .cfg_reject);
	dasp_partner p0 (.clk, .txd(txd[0]), .rxd(rxd[0]));
	dasp_partner p1 (.clk, .txd(txd[1]), .rxd(rxd[1]));

	// ****************************************
	// Shared tasks
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Bit time in clocks: rounded divisor of the reference, four clocks a tick
	function automatic int bit_clocks(input int b);
		return ((REF_HZ + b / 2) / b) * REF_DIV;
	endfunction
	task automatic final_report();
		$display("Counts: checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// A hang ends the run instead of eating the time budget
	task automatic limit(input int t);
		if (t >= LIM) begin
			chk("wait bound", 0, t);
			final_report();
		end
	endtask
	task automatic tx(input int ch, input logic [7:0] b, output int t);
		t = 0;
		tx_req[ch] = {1'b1, b};
		do begin
			@(negedge clk);
			t++;
		end while (tx_ack[ch] !== 1'b1 && t < LIM);
		limit(t);
		tx_req[ch] = '0;
		// Let an edge pass so a following request never re-drives in one step
		@(negedge clk);
	endtask
	task automatic rx(input int ch, input logic [7:0] exp);
		int t = 0;
		rx_req[ch] = 1'b1;
		do begin
			@(negedge clk);
			t++;
		end while (rx_ack[ch] !== 1'b1 && t < LIM);
		limit(t);
		rx_req[ch] = 1'b0;
		chk("received byte", exp, rx_data[ch]);
		@(negedge clk);
	endtask
	// Start bit length; callers send bytes with bit 0 set
	task automatic bitlen(input int ch, output int n);
		int t = 0;
		n = 0;
		while (txd[ch] !== 1'b0 && t < LIM) begin
			@(negedge clk);
			t++;
		end
		while (txd[ch] === 1'b0 && n < LIM) begin
			@(negedge clk);
			n++;
		end
		limit(t);
		limit(n);
	endtask
	task automatic idle(input int ch);
		int t = 0;
		while (tx_ready[ch] !== 1'b1 && t < LIM) begin
			@(negedge clk);
			t++;
		end
		limit(t);
	endtask
	task automatic cfgw(input int ch, input logic bw, input logic [15:0] bd, input logic [7:0] ql);
		cfg[ch] = '{bw, bd, !bw, 1'b0, ql};
		@(negedge clk);
		cfg[ch] = '0;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_reset_rate();
		int n;
		int t;
		fork
			p0.send(8'h3C);
			rx(0, 8'h3C);
			begin
				tx(0, 8'h41, t);
				bitlen(0, n);
			end
		join
		chk("reset bit clocks", bit_clocks(16'h2580), n);
		idle(0);
		chk("terminal byte", 8'h41, p0.got);
		chk("stop bit", 1, p0.stop_ok);
	endtask
	task automatic s_baud();
		int n;
		int t;
		int rates[3] = '{16'h4B00, 16'h9600, 16'hE100};
		logic [7:0] bytes[3] = '{8'h81, 8'h93, 8'hC7};
		foreach (rates[i]) begin
			cfgw(0, 1'b1, rates[i][15:0], 8'h00);
			p0.bit_clk = bit_clocks(rates[i]);
			tx(0, bytes[i], t);
			bitlen(0, n);
			chk("bit clocks", bit_clocks(rates[i]), n);
			idle(0);
			chk("terminal byte", bytes[i], p0.got);
		end
		cfgw(1, 1'b1, 16'hE100, 8'h00);
		@(negedge clk);
		cfgw(1, 1'b1, 16'hEA60, 8'h00);
		p1.bit_clk = bit_clocks(16'hE100);
		tx(1, 8'hA5, t);
		bitlen(1, n);
		chk("aux bit clocks", bit_clocks(16'hE100), n);
		chk("ready while busy", 0, tx_ready[1]);
		tx(1, 8'h5A, t);
		chk("stall in frame", 1, t <= 10 * bit_clocks(16'hE100));
		idle(1);
		chk("aux frames", 2, p1.n_got);
		chk("aux byte", 8'h5A, p1.got);
	endtask
	task automatic s_overrun();
		p1.send(8'h11);
		p1.send(8'h22);
		chk("overrun", 1, overrun[1]);
		chk("available", 1, rx_avail[1]);
		rx(1, 8'h11);
		chk("overrun cleared", 0, overrun[1]);
		chk("available", 0, rx_avail[1]);
		fork
			p1.send(8'h33);
			rx(1, 8'h33);
		join
	endtask
	// Receive queue only, never shared with transmit
	task automatic s_queue();
		logic seen;
		cfgw(1, 1'b0, 16'h0000, 8'h04);
		seen = cfg_reject[1];
		@(negedge clk);
		chk("short queue refused", 1, seen | cfg_reject[1]);
		cfgw(1, 1'b0, 16'h0000, 8'h07);
		seen = cfg_reject[1];
		@(negedge clk);
		chk("queue refused", 0, seen | cfg_reject[1]);
		for (int i = 1; i <= 4; i++) begin
			p1.send(8'(i));
		end
		chk("queue overrun", 1, overrun[1]);
		for (int i = 1; i <= 3; i++) begin
			rx(1, 8'(i));
		end
		chk("queue empty", 0, rx_avail[1]);
	endtask
	// Transmit queue of length 6 holds two bytes behind the shifter
	task automatic s_txq();
		int t;
		int base;
		base = p1.n_got;
		cfg[1] = '{1'b0, 16'h0000, 1'b0, 1'b1, 8'h06};
		@(negedge clk);
		cfg[1] = '0;
		tx(1, 8'h0F, t);
		tx(1, 8'h1E, t);
		tx(1, 8'h2D, t);
		chk("queued take quick", 1, t <= 4);
		chk("ready when queue full", 0, tx_ready[1]);
		t = 0;
		while (p1.n_got < base + 3 && t < LIM) begin
			@(negedge clk);
			t++;
		end
		limit(t);
		chk("queued frames", base + 3, p1.n_got);
		chk("last queued byte", 8'h2D, p1.got);
		chk("ready with space", 1, tx_ready[1]);
	endtask

	initial begin
		rstn = 1'b0;
		tx_req = '0;
		rx_req = '0;
		cfg = '0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		s_reset_rate();
		s_baud();
		s_overrun();
		s_queue();
		s_txq();
		final_report();
	end
endmodule

bind dasp_top dasp_assertions i_chk (.clk, .rstn, .rxd, .txd, .tx_req, .tx_ack, .tx_ready,
	.rx_req, .rx_ack, .rx_data, .rx_avail, .overrun, .cfg, .cfg_reject);
`default_nettype wire
